// file: core/interrupt_request_controller.sv
// interrupt request controller with an axi4-lite register slave
// Notes on behaviour
// RQ1 - four registers decoded at offsets 0x00-0x0c
// RQ2 - masked status is raw AND enable
// RQ3 - raw status shows live source requests
// RQ4 - status registers ignore writes
// RQ5 - bits 31:28 read zero always
// RQ6 - enable-set reads enables, write one enables
// RQ7 - enable-clear one bit disables source
// RQ8 - enable-clear zero bits change nothing
// RQ9 - software avoids reading offsets 0x10-0x18
// RQ10 - bit 27 is battery monitor request
// RQ11 - bits 26-23 are port f pins 7-4
// RQ12 - bits 22-16 timer3 down to serial3
// RQ13 - bits 15-8 sync serial down to timer1
// RQ14 - bits 7-5 port f 3-1, bit 4 audio
// RQ15 - bit 3 media change after 62.5 us
// RQ16 - bit 2 watchdog overflow request
// RQ17 - bit 1 battery low debounced 62.5 us
// RQ18 - bit 0 port f pin 0 fast
// RQ19 - bits 27-4 normal, 3-0 fast request
// RQ20 - enable-set zero bits change nothing
// RQ21 - reset clears every enable bit
// RQ22 - enable-clear always reads zero
// RQ23 - request outputs are OR of masked bits
//
// The AXI4-Lite interface to the registers was left to the implementer.
`default_nettype none
`include "irq_ctrl_consts.svh"
module interrupt_request_controller
   import irq_ctrl_pkg::*;
#(
   parameter int unsigned DEBOUNCE_CYCLES = `IRQC_DEBOUNCE_CYC
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   // axi4-lite write address
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   // axi4-lite write response
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read address
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   // axi4-lite read data
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // normal sources, bits 27 down to 4
   input  wire logic        battery_monitor_req,
   input  wire logic        port_f7_req,
   input  wire logic        port_f6_req,
   input  wire logic        port_f5_req,
   input  wire logic        port_f4_req,
   input  wire logic        timer3_req,
   input  wire logic        dma_req,
   input  wire logic        usb_req,
   input  wire logic        card_ctrl_req,
   input  wire logic        codec_link_req,
   input  wire logic        smart_card_req,
   input  wire logic        serial3_req,
   input  wire logic        sync_serial_req,
   input  wire logic        display_req,
   input  wire logic        serial2_req,
   input  wire logic        serial1_req,
   input  wire logic        tick_req,
   input  wire logic        calendar_clock_req,
   input  wire logic        timer2_req,
   input  wire logic        timer1_req,
   input  wire logic        port_f3_req,
   input  wire logic        port_f2_req,
   input  wire logic        port_f1_req,
   input  wire logic        audio_codec_req,
   // fast sources and raw pins
   input  wire logic        media_change_in,
   input  wire logic        watchdog_req,
   input  wire logic        no_ext_power_in,
   input  wire logic        battery_good_in,
   input  wire logic        port_f0_fast_req,
   // requests to the core
   output var  logic        irq_out,
   output var  logic        fast_irq_out
);

   src_vec_t  raw_status;
   src_vec_t  enable;
   src_vec_t  masked;
   logic      media_change_req;
   logic      battery_low_req;
   deb_cnt_t  media_cnt;
   deb_cnt_t  batlow_cnt;
   logic      batlow_cond;
   wr_state_e wr_state;
   logic      aw_held;
   logic      w_held;
   logic [7:0]  aw_ofs;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic      wr_fire;
   logic [27:0] wr_bits;

   localparam deb_cnt_t DEB_LAST = deb_cnt_t'(DEBOUNCE_CYCLES - 1);

   // media change debounce: input must stay active the full window
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         media_cnt        <= '0;
         media_change_req <= 1'b0;
      end else if (!media_change_in) begin
         media_cnt        <= '0;
         media_change_req <= 1'b0;
      end else if (media_cnt == DEB_LAST) begin
         media_change_req <= 1'b1; // [RQ15]
      end else begin
         media_cnt <= media_cnt + deb_cnt_t'(1);
      end
   end

   // battery low holds while both conditions last
   assign batlow_cond = no_ext_power_in & ~battery_good_in;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         batlow_cnt      <= '0;
         battery_low_req <= 1'b0;
      end else if (!batlow_cond) begin
         batlow_cnt      <= '0;
         battery_low_req <= 1'b0;
      end else if (batlow_cnt == DEB_LAST) begin
         battery_low_req <= 1'b1; // [RQ17]
      end else begin
         batlow_cnt <= batlow_cnt + deb_cnt_t'(1);
      end
   end

   // source order fixes bit positions in every register
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         raw_status <= '0;
      end else begin
         raw_status <= {battery_monitor_req, // [RQ10] [RQ3]
                        port_f7_req, port_f6_req,
                        port_f5_req, port_f4_req, // [RQ11]
                        timer3_req, dma_req, usb_req, card_ctrl_req,
                        codec_link_req, smart_card_req,
                        serial3_req, // [RQ12]
                        sync_serial_req, display_req, serial2_req,
                        serial1_req, tick_req, calendar_clock_req,
                        timer2_req, timer1_req, // [RQ13]
                        port_f3_req, port_f2_req, port_f1_req,
                        audio_codec_req, // [RQ14]
                        media_change_req,
                        watchdog_req, // [RQ16]
                        battery_low_req,
                        port_f0_fast_req}; // [RQ18]
      end
   end

   assign masked = raw_status & enable; // [RQ2]

   // no priority among sources; the level follows the masked bits
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         irq_out      <= 1'b0;
         fast_irq_out <= 1'b0;
      end else begin
         irq_out      <=
            |masked[`IRQC_NUM_SRC-1:`IRQC_FAST_TOP+1]; // [RQ19] [RQ23]
         fast_irq_out <= |masked[`IRQC_FAST_TOP:0]; // [RQ19] [RQ23]
      end
   end

   // write channel: address and data latched in either order
   assign wr_fire = aw_held & w_held & (wr_state == wr_idle);

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         aw_held <= 1'b0;
         aw_ofs  <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_ofs  <= s_axi_awaddr[7:0];
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
      end else begin
         if (s_axi_awvalid && s_axi_awready) s_axi_awready <= 1'b0;
         else if (s_axi_bvalid && s_axi_bready) s_axi_awready <= 1'b1;
         if (s_axi_wvalid && s_axi_wready) s_axi_wready <= 1'b0;
         else if (s_axi_bvalid && s_axi_bready) s_axi_wready <= 1'b1;
      end
   end

   // byte strobes gate which enable bits a write may touch
   generate
      for (genvar b = 0; b < `IRQC_NUM_SRC; b++) begin : g_wbits
         assign wr_bits[b] = w_data[b] & w_strb[b/8];
      end
   endgenerate

   // set and clear writes only ever act on their one bits
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         enable <= `IRQC_ENABLE_RESET; // [RQ21]
      end else if (wr_fire && aw_ofs == `IRQC_OFS_ENSET) begin
         enable <= enable | wr_bits; // [RQ6] [RQ20]
      end else if (wr_fire && aw_ofs == `IRQC_OFS_ENCLR) begin
         enable <= enable & ~wr_bits; // [RQ7] [RQ8]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         wr_state     <= wr_idle;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `IRQC_RESP_OKAY;
      end else unique case (wr_state)
         wr_idle: if (wr_fire) begin
            wr_state     <= wr_resp;
            s_axi_bvalid <= 1'b1;
            // status writes accepted and dropped [RQ4]
            s_axi_bresp  <= (aw_ofs[7:4] == 4'h0 && aw_ofs[1:0] == 2'b00)
                            ? `IRQC_RESP_OKAY : `IRQC_RESP_SLVERR; // [RQ1]
         end
         wr_resp: if (s_axi_bready) begin
            wr_state     <= wr_idle;
            s_axi_bvalid <= 1'b0;
         end
      endcase
   end

   // read channel: one outstanding read, answer one cycle after address
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `IRQC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= `IRQC_RESP_OKAY;
         unique case (s_axi_araddr[7:0])
            `IRQC_OFS_MASKED: s_axi_rdata <= {4'h0, masked}; // [RQ1] [RQ5]
            `IRQC_OFS_RAW:    s_axi_rdata <= {4'h0, raw_status}; // [RQ3]
            `IRQC_OFS_ENSET:  s_axi_rdata <= {4'h0, enable}; // [RQ6]
            `IRQC_OFS_ENCLR:  s_axi_rdata <= 32'h0000_0000; // [RQ22]
            default: begin
               // reserved offsets answer zero with an error
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `IRQC_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // checks
   property p_masked_and;
      @(posedge clk_sys) disable iff (!resetn)
      1'b1 |=> (irq_out == |$past(masked[27:4])) &&
               (fast_irq_out == |$past(masked[3:0]));
   endproperty
   a_masked_and: assert property (p_masked_and) // [RQ19] [RQ23]
      else $error("request outputs do not follow masked status");

   property p_set_write;
      @(posedge clk_sys) disable iff (!resetn)
      (wr_fire && aw_ofs == `IRQC_OFS_ENSET) |=>
         ((enable & $past(wr_bits)) == $past(wr_bits)) &&
         ((enable & $past(enable)) == $past(enable));
   endproperty
   a_set_write: assert property (p_set_write) // [RQ20]
      else $error("enable-set write lost or cleared bits");

   property p_clr_write;
      @(posedge clk_sys) disable iff (!resetn)
      (wr_fire && aw_ofs == `IRQC_OFS_ENCLR) |=>
         (enable == ($past(enable) & ~$past(wr_bits)));
   endproperty
   a_clr_write: assert property (p_clr_write) // [RQ7]
      else $error("enable-clear write wrong result");

   property p_status_ro;
      @(posedge clk_sys) disable iff (!resetn)
      (wr_fire && aw_ofs[7:3] == 5'h00) |=> $stable(enable);
   endproperty
   a_status_ro: assert property (p_status_ro) // [RQ4]
      else $error("status write changed enables");

   property p_reserved_zero;
      @(posedge clk_sys) disable iff (!resetn)
      s_axi_rvalid |-> s_axi_rdata[31:28] == 4'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) // [RQ5]
      else $error("reserved bits read nonzero");

   property p_clr_reads_zero;
      @(posedge clk_sys) disable iff (!resetn)
      (s_axi_arvalid && s_axi_arready &&
       s_axi_araddr[7:0] == `IRQC_OFS_ENCLR) |=> (s_axi_rdata == 32'h0);
   endproperty
   a_clr_reads_zero: assert property (p_clr_reads_zero) // [RQ22]
      else $error("enable-clear read nonzero");

   property p_media_deb;
      @(posedge clk_sys) disable iff (!resetn)
      $rose(media_change_req) |-> media_cnt == DEB_LAST;
   endproperty
   a_media_deb: assert property (p_media_deb) // [RQ15]
      else $error("media change raised before debounce");

   property p_batlow_drop;
      @(posedge clk_sys) disable iff (!resetn)
      !batlow_cond |=> !battery_low_req;
   endproperty
   a_batlow_drop: assert property (p_batlow_drop) // [RQ17]
      else $error("battery low held without condition");

   property p_enable_reset;
      @(posedge clk_sys)
      !resetn |=> enable == 28'h0;
   endproperty
   a_enable_reset: assert property (p_enable_reset) // [RQ21]
      else $error("enables not cleared by reset");

endmodule : interrupt_request_controller
`default_nettype wire

// file: core/irq_ctrl_consts.svh
// register offsets, field positions, reset values and timing counts
`ifndef IRQ_CTRL_CONSTS_SVH
`define IRQ_CTRL_CONSTS_SVH
`define IRQC_BASE_ADDR     32'h8000_0500
`define IRQC_OFS_MASKED    8'h00
`define IRQC_OFS_RAW       8'h04
`define IRQC_OFS_ENSET     8'h08
`define IRQC_OFS_ENCLR     8'h0c
`define IRQC_NUM_SRC       28
`define IRQC_FAST_TOP      3
`define IRQC_BIT_BATMON    27
`define IRQC_BIT_MEDIA     3
`define IRQC_BIT_WDOG      2
`define IRQC_BIT_BATLOW    1
`define IRQC_BIT_PF0       0
`define IRQC_ENABLE_RESET  28'h000_0000
`define IRQC_DEBOUNCE_NS   62500
`define IRQC_CLK_PERIOD_NS 10
`define IRQC_DEBOUNCE_CYC \
   ((`IRQC_DEBOUNCE_NS + `IRQC_CLK_PERIOD_NS - 1) / `IRQC_CLK_PERIOD_NS)
`define IRQC_RESP_OKAY     2'b00
`define IRQC_RESP_SLVERR   2'b10
`endif

// file: core/irq_ctrl_pkg.sv
// types shared by the interrupt request controller
`default_nettype none
package irq_ctrl_pkg;
   typedef logic [27:0] src_vec_t;
   typedef logic [12:0] deb_cnt_t;
   typedef enum logic [1:0] {
      wr_idle = 2'b00,
      wr_resp = 2'b01
   } wr_state_e;
endpackage : irq_ctrl_pkg
`default_nettype wire

// file: sim/interrupt_request_controller_tb_top.sv
// self-checking bench for the interrupt request controller
`default_nettype none
`include "irq_ctrl_consts.svh"
module interrupt_request_controller_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] base = `IRQC_BASE_ADDR;
   localparam logic [7:0]  msk = `IRQC_OFS_MASKED;
   localparam logic [7:0]  raw = `IRQC_OFS_RAW;
   localparam logic [7:0]  ens = `IRQC_OFS_ENSET;
   localparam logic [7:0]  enc = `IRQC_OFS_ENCLR;
   localparam logic [1:0]  ok = `IRQC_RESP_OKAY;
   localparam logic [1:0]  err = `IRQC_RESP_SLVERR;
   logic        clk_sys, resetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, irq_o, fiq_o;
   logic        no_pwr, bat_good;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic [1:0]  bresp, rresp;
   logic [27:0] src;
   logic [7:0]  irq_n, fiq_n;
   int          num_errors, checks_done;

   interrupt_request_controller #(.DEBOUNCE_CYCLES(8)) dut (
      .clk_sys(clk_sys), .resetn(resetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .battery_monitor_req(src[27]), .port_f7_req(src[26]),
      .port_f6_req(src[25]), .port_f5_req(src[24]), .port_f4_req(src[23]),
      .timer3_req(src[22]), .dma_req(src[21]), .usb_req(src[20]),
      .card_ctrl_req(src[19]), .codec_link_req(src[18]),
      .smart_card_req(src[17]), .serial3_req(src[16]),
      .sync_serial_req(src[15]), .display_req(src[14]),
      .serial2_req(src[13]), .serial1_req(src[12]), .tick_req(src[11]),
      .calendar_clock_req(src[10]), .timer2_req(src[9]),
      .timer1_req(src[8]), .port_f3_req(src[7]), .port_f2_req(src[6]),
      .port_f1_req(src[5]), .audio_codec_req(src[4]),
      .media_change_in(src[3]), .watchdog_req(src[2]),
      .no_ext_power_in(no_pwr), .battery_good_in(bat_good),
      .port_f0_fast_req(src[0]), .irq_out(irq_o), .fast_irq_out(fiq_o));

   irq_core_model core (.clk_sys(clk_sys), .resetn(resetn), .irq_out(irq_o),
      .fast_irq_out(fiq_o), .irq_entries(irq_n), .fiq_entries(fiq_n));

   always #5 clk_sys = ~clk_sys;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] ofs, input logic [31:0] d,
                     input logic [1:0] er);
      logic [1:0] r;
      r = 'x;
      @(posedge clk_sys);
      awaddr <= base + {24'h0, ofs};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clk_sys);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            break;
         end
      end
      bready <= 1'b0;
      chk({30'h0, r}, {30'h0, er});
   endtask

   task automatic rd(input logic [7:0] ofs, input logic [31:0] ed,
                     input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      d = 'x;
      r = 'x;
      @(posedge clk_sys);
      araddr <= base + {24'h0, ofs};
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clk_sys);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            break;
         end
      end
      rready <= 1'b0;
      chk(d, ed);
      chk({30'h0, r}, {30'h0, er});
   endtask

   task automatic outs(input logic i, input logic f);
      chk({30'h0, irq_o, fiq_o}, {30'h0, i, f});
   endtask

   task automatic t_regs();
      rd(msk, 32'h0, ok);
      rd(raw, 32'h0, ok);
      rd(ens, 32'h0, ok);
      wr(ens, 32'hffff_ffff, ok);
      rd(ens, 32'h0fff_ffff, ok);
      wr(enc, 32'hf000_00f0, ok);
      rd(ens, 32'h0fff_ff0f, ok);
      wr(ens, 32'h0, ok);
      wr(enc, 32'h0, ok);
      rd(ens, 32'h0fff_ff0f, ok);
      rd(enc, 32'h0, ok);
      wr(msk, 32'hffff_ffff, ok);
      wr(raw, 32'hffff_ffff, ok);
      rd(msk, 32'h0, ok);
      rd(raw, 32'h0, ok);
      // unmapped place chosen outside the unpredictable ones
      wr(8'h20, 32'h0000_00f0, err);
      rd(8'h20, 32'h0, err);
      rd(ens, 32'h0fff_ff0f, ok);
      resetn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      rd(ens, 32'h0, ok);
   endtask

   task automatic t_walk();
      logic [7:0] ni;
      logic [7:0] nf;
      ni = irq_n;
      nf = fiq_n;
      wr(ens, 32'hffff_ffff, ok);
      for (int i = 0; i < 28; i++) begin
         if (i == 1 || i == 3) continue;
         src <= 28'h1 << i;
         repeat (3) @(posedge clk_sys);
         outs(i > 3, i < 4);
         rd(raw, 32'h1 << i, ok);
         rd(msk, 32'h1 << i, ok);
      end
      src <= 28'h0;
      wr(enc, 32'h0fff_ffff, ok);
      src <= 28'hfff_fff5;
      repeat (3) @(posedge clk_sys);
      outs(1'b0, 1'b0);
      rd(raw, 32'h0fff_fff5, ok);
      rd(msk, 32'h0, ok);
      src <= 28'h0;
      // adjacent sources of one group keep the level up: one entry each
      chk({24'h0, irq_n}, {24'h0, ni + 8'h01});
      chk({24'h0, fiq_n}, {24'h0, nf + 8'h01});
   endtask

   task automatic t_deb();
      logic [7:0] n;
      wr(ens, 32'h0000_000a, ok);
      n = fiq_n;
      src[3] <= 1'b1;
      // a burst one cycle short of the debounce span must not get through
      repeat (7) @(posedge clk_sys);
      src[3] <= 1'b0;
      repeat (6) @(posedge clk_sys);
      chk({24'h0, fiq_n}, {24'h0, n});
      src[3] <= 1'b1;
      // debounce span plus two register stages before the line rises
      repeat (10) @(posedge clk_sys);
      outs(1'b0, 1'b0);
      @(posedge clk_sys);
      outs(1'b0, 1'b1);
      rd(raw, 32'h8, ok);
      src[3] <= 1'b0;
      repeat (4) @(posedge clk_sys);
      outs(1'b0, 1'b0);
      no_pwr <= 1'b1;
      bat_good <= 1'b0;
      repeat (10) @(posedge clk_sys);
      outs(1'b0, 1'b0);
      @(posedge clk_sys);
      outs(1'b0, 1'b1);
      rd(msk, 32'h2, ok);
      bat_good <= 1'b1;
      repeat (4) @(posedge clk_sys);
      outs(1'b0, 1'b0);
      no_pwr <= 1'b0;
      chk({24'h0, fiq_n}, {24'h0, n + 8'h02});
   endtask

   task automatic complete_run();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      #100us;
      num_errors++;
      complete_run();
   end

   initial begin
      clk_sys = 1'b0;
      resetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, no_pwr} = 6'h00;
      bat_good = 1'b1;
      src = 28'h0;
      {awaddr, wdata, araddr} = 96'h0;
      num_errors = 0;
      checks_done = 0;
      repeat (12) @(posedge clk_sys);
      resetn <= 1'b1;
      t_regs();
      t_walk();
      t_deb();
      complete_run();
   end
endmodule // interrupt_request_controller_tb_top
`default_nettype wire

// file: sim/irq_core_model.sv
// core model that counts entries into normal and fast handling
`default_nettype none
module irq_core_model (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       resetn,
   // request levels from the controller
   input  wire logic       irq_out,
   input  wire logic       fast_irq_out,
   // handler entry counts
   output var  logic [7:0] irq_entries,
   output var  logic [7:0] fiq_entries
);
   timeunit 1ns;
   timeprecision 1ps;
   logic irq_q;
   logic fiq_q;
   // a level request enters its handler once per rise, like a real core
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         irq_q <= 1'b0;
         fiq_q <= 1'b0;
         irq_entries <= 8'h00;
         fiq_entries <= 8'h00;
      end else begin
         irq_q <= irq_out;
         fiq_q <= fast_irq_out;
         if (irq_out && !irq_q) irq_entries <= irq_entries + 8'h01;
         if (fast_irq_out && !fiq_q) fiq_entries <= fiq_entries + 8'h01;
      end
   end
endmodule // irq_core_model
`default_nettype wire
